/* shared/dfp_pkg.sv */
// Constants, rate tables and mode type for the digital system interface port.
// Assumes a 250 MHz core clock; every bit clock half period is derived from it.
package dfp_pkg;

   // ************************************************************
   // Clock and frame figures
   // ************************************************************
   localparam int unsigned CORE_HZ = 250_000_000;
   localparam int unsigned FRAME_HZ = 8_000;
   localparam int unsigned F256K_HZ = 256_000;
   localparam int unsigned F512K_HZ = 512_000;
   localparam int unsigned F1536K_HZ = 1_536_000;
   localparam int unsigned F2048K_HZ = 2_048_000;
   localparam int unsigned F2560K_HZ = 2_560_000;
   localparam int CNT_W = 10;
   // Half periods round down so the produced clock is never slower than named
   localparam logic [CNT_W-1:0] HALF_256K = CNT_W'(CORE_HZ / (2 * F256K_HZ));
   localparam logic [CNT_W-1:0] HALF_512K = CNT_W'(CORE_HZ / (2 * F512K_HZ));
   localparam logic [CNT_W-1:0] HALF_1536K = CNT_W'(CORE_HZ / (2 * F1536K_HZ));
   localparam logic [CNT_W-1:0] HALF_2048K = CNT_W'(CORE_HZ / (2 * F2048K_HZ));
   localparam logic [CNT_W-1:0] HALF_2560K = CNT_W'(CORE_HZ / (2 * F2560K_HZ));

   // ************************************************************
   // Rate codes, channel layout, reset values
   // ************************************************************
   localparam logic [2:0] RATE_256K = 3'h0;
   localparam logic [2:0] RATE_512K = 3'h1;
   localparam logic [2:0] RATE_1536K = 3'h2;
   localparam logic [2:0] RATE_2048K = 3'h3;
   localparam logic [2:0] RATE_2560K = 3'h4;
   localparam logic [CNT_W-1:0] B_BITS = 10'h010;
   localparam logic [CNT_W-1:0] BD_BITS = 10'h012;
   localparam logic [CNT_W-1:0] GCI_B2_CYC = 10'h010;
   localparam logic [CNT_W-1:0] GCI_B2_END = 10'h011;
   localparam logic [CNT_W-1:0] CYC_IDLE = 10'h3ff;
   localparam logic [CNT_W-1:0] DIV_RST = 10'h000;

   typedef enum logic [1:0] {DFP_TDM_SLAVE, DFP_TDM_MASTER, DFP_GCI_SLAVE, DFP_GCI_MASTER} dfp_mode_t;

   function automatic logic [CNT_W-1:0] dfp_half(input logic [2:0] rate);
      case (rate)
         RATE_512K: dfp_half = HALF_512K;
         RATE_1536K: dfp_half = HALF_1536K;
         RATE_2048K: dfp_half = HALF_2048K;
         RATE_2560K: dfp_half = HALF_2560K;
         default: dfp_half = HALF_256K;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] dfp_frame_len(input logic [2:0] rate);
      case (rate)
         RATE_512K: dfp_frame_len = CNT_W'(F512K_HZ / FRAME_HZ);
         RATE_1536K: dfp_frame_len = CNT_W'(F1536K_HZ / FRAME_HZ);
         RATE_2048K: dfp_frame_len = CNT_W'(F2048K_HZ / FRAME_HZ);
         RATE_2560K: dfp_frame_len = CNT_W'(F2560K_HZ / FRAME_HZ);
         default: dfp_frame_len = CNT_W'(F256K_HZ / FRAME_HZ);
      endcase
   endfunction

   // Bit clock cycle to data bit index; in GCI each bit spans two cycles
   function automatic logic [CNT_W-1:0] dfp_bit_idx(input logic [CNT_W-1:0] cyc, input logic gci);
      dfp_bit_idx = gci ? {1'b0, cyc[CNT_W-1:1]} : cyc;
   endfunction

endpackage

/* hw/dfp_port.sv */
// Serial frame port: B and D channel bits between backplane pins and channel words.
// Assumes pin inputs are asynchronous to i_core_clk and a bit clock far below it.
`timescale 1ns/1ps
module dfp_port
   import dfp_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Straps
   input wire logic i_format_select_pin,
   input wire logic i_clock_direction_select,
   input wire logic i_gci_clk_select,
   // Configuration
   input wire logic i_tdm_master,
   input wire logic [2:0] i_bclk_rate_sel,
   input wire logic i_d_route_en,
   input wire logic i_lt_mode,
   // Bit clock pin
   input wire logic i_bclk,
   output logic o_bclk,
   output logic o_bclk_oe,
   // Frame sync pins
   input wire logic i_tx_frame_sync,
   output logic o_tx_frame_sync,
   output logic o_tx_frame_sync_oe,
   input wire logic i_rx_frame_sync,
   output logic o_rx_frame_sync,
   output logic o_rx_frame_sync_oe,
   // Serial data pins
   input wire logic i_serial_tx_in,
   output logic o_serial_rx_out,
   output logic o_serial_rx_out_oe,
   // Channel words toward the line
   output logic [7:0] o_tx_b1,
   output logic [7:0] o_tx_b2,
   output logic [1:0] o_tx_d,
   output logic o_tx_strobe,
   // Channel words from the line
   input wire logic [7:0] i_rx_b1,
   input wire logic [7:0] i_rx_b2,
   input wire logic [1:0] i_rx_d,
   // Status
   output logic o_nt_mode,
   output logic o_gci_mode,
   output logic o_master
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] pin_s1_q, pin_s2_q;
   logic bclk_s, txfs_s, rxfs_s, txin_s, fmt_s, cds_s, cls_s;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else
      begin
         pin_s1_q <= {i_bclk, i_tx_frame_sync, i_rx_frame_sync, i_serial_tx_in,
                      i_format_select_pin, i_clock_direction_select, i_gci_clk_select};
         pin_s2_q <= pin_s1_q;
      end
   end
   assign {bclk_s, txfs_s, rxfs_s, txin_s, fmt_s, cds_s, cls_s} = pin_s2_q;

   // ************************************************************
   // Mode decode
   // ************************************************************
   dfp_mode_t mode;
   logic gci, master, d_route;
   logic [2:0] rate;
   logic [CNT_W-1:0] half, frame_len, last_bit, slot_end;

   always_comb
   begin
      mode = fmt_s ? (i_tdm_master ? DFP_TDM_MASTER : DFP_TDM_SLAVE) :
                     (cds_s ? DFP_GCI_MASTER : DFP_GCI_SLAVE);
      gci = 1'b0;
      master = 1'b0;
      rate = i_bclk_rate_sel;
      case (mode)
         DFP_TDM_MASTER: master = 1'b1;
         DFP_GCI_SLAVE: gci = 1'b1;
         DFP_GCI_MASTER:
         begin
            gci = 1'b1;
            master = 1'b1;
            rate = cls_s ? RATE_1536K : RATE_512K;
         end
         default: master = 1'b0;
      endcase
      d_route = i_d_route_en;
      half = dfp_half(rate);
      frame_len = dfp_frame_len(rate);
      last_bit = d_route ? BD_BITS : B_BITS;
      // Slot length in bit clock cycles; a GCI bit spans two
      slot_end = gci ? {last_bit[CNT_W-2:0], 1'b0} : last_bit;
   end

   // Role is forced to network termination only by a GCI master strap
   assign o_nt_mode = (gci && master) ? 1'b1 : !i_lt_mode;
   assign o_gci_mode = gci;
   assign o_master = master;
   assign o_bclk_oe = master;
   assign o_tx_frame_sync_oe = master;
   assign o_rx_frame_sync_oe = master;

   // ************************************************************
   // Framing and data state
   // ************************************************************
   logic [CNT_W-1:0] div_q, div_d, tx_cyc_q, tx_cyc_d, rx_cyc_q, rx_cyc_d;
   logic bclk_q, bclk_d, bclk_prev_q, txfs_prev_q, txfs_prev_d, rxfs_prev_q, rxfs_prev_d;
   logic txfs_o_q, txfs_o_d, rxfs_o_q, rxfs_o_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
   logic strobe_q, strobe_d, rise, fall, tx_start, rx_start, div_wrap;
   logic [17:0] tx_sr_q, tx_sr_d, rx_word_q, rx_word_d, rx_now, tx_word_q, tx_word_d;
   logic [CNT_W-1:0] tx_idx, rx_idx_d;

   always_comb
   begin
      div_wrap = (div_q >= half - 10'h001);
      div_d = div_wrap ? DIV_RST : div_q + 10'h001;
      bclk_d = div_wrap ? !bclk_q : bclk_q;
      rise = master ? (div_wrap && !bclk_q) : (bclk_s && !bclk_prev_q);
      fall = master ? (div_wrap && bclk_q) : (!bclk_s && bclk_prev_q);
      // Frame sync inputs are looked at only on bit clock rises
      tx_start = rise && txfs_s && !txfs_prev_q;
      rx_start = rise && (gci ? tx_start : (rxfs_s && !rxfs_prev_q));
      txfs_prev_d = rise ? txfs_s : txfs_prev_q;
      rxfs_prev_d = rise ? rxfs_s : rxfs_prev_q;
      tx_cyc_d = tx_cyc_q;
      rx_cyc_d = rx_cyc_q;
      txfs_o_d = txfs_o_q;
      rxfs_o_d = rxfs_o_q;
      if (rise && master)
      begin
         // Wrap on or past the end so a count left by another mode or rate restarts at once
         tx_cyc_d = (tx_cyc_q >= frame_len - 10'h001) ? 10'h000 : tx_cyc_q + 10'h001;
         rx_cyc_d = tx_cyc_d;
         txfs_o_d = (tx_cyc_d == 10'h000);
         // GCI marks B2 on the second sync; TDM uses one slot for both ways
         rxfs_o_d = gci ? (tx_cyc_d == GCI_B2_CYC || tx_cyc_d == GCI_B2_END)
                        : (tx_cyc_d == 10'h000);
      end
      else if (rise)
      begin
         // Slave counters go idle past the slot, so a format or D routing change between
         // frames cannot reopen the slot without a fresh sync
         tx_cyc_d = (tx_cyc_q >= slot_end) ? CYC_IDLE : tx_cyc_q + 10'h001;
         tx_cyc_d = tx_start ? 10'h000 : tx_cyc_d;
         rx_cyc_d = (rx_cyc_q >= slot_end) ? CYC_IDLE : rx_cyc_q + 10'h001;
         rx_cyc_d = rx_start ? 10'h000 : rx_cyc_d;
      end
      // Receive side drives on rises from the word latched at slot start
      rx_now = {i_rx_b1, i_rx_b2, i_rx_d};
      rx_word_d = (rise && rx_cyc_d == 10'h000) ? rx_now : rx_word_q;
      rx_idx_d = dfp_bit_idx(rx_cyc_d, gci);
      rxo_d = rxo_q;
      rxoe_d = rxoe_q;
      if (rise)
      begin
         rxoe_d = (rx_idx_d < last_bit);
         rxo_d = (rx_idx_d < last_bit) ? rx_word_d[5'(10'h011 - rx_idx_d)] : 1'b1;
      end
      // Transmit side samples on falls, on the second cycle of a GCI bit
      tx_idx = dfp_bit_idx(tx_cyc_q, gci);
      tx_sr_d = tx_sr_q;
      tx_word_d = tx_word_q;
      strobe_d = 1'b0;
      if (fall && tx_idx < last_bit && (!gci || tx_cyc_q[0]))
      begin
         tx_sr_d = {tx_sr_q[16:0], txin_s};
         if (tx_idx == last_bit - 10'h001)
         begin
            strobe_d = 1'b1;
            tx_word_d = d_route ? tx_sr_d : {tx_sr_d[15:0], 2'h0};
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         div_q <= DIV_RST;
         tx_cyc_q <= CYC_IDLE;
         rx_cyc_q <= CYC_IDLE;
         bclk_q <= 1'b0;
         bclk_prev_q <= 1'b0;
         txfs_prev_q <= 1'b0;
         rxfs_prev_q <= 1'b0;
         txfs_o_q <= 1'b0;
         rxfs_o_q <= 1'b0;
         rxo_q <= 1'b1;
         rxoe_q <= 1'b0;
         strobe_q <= 1'b0;
         tx_sr_q <= '0;
         rx_word_q <= '0;
         tx_word_q <= '0;
      end
      else
      begin
         div_q <= div_d;
         tx_cyc_q <= tx_cyc_d;
         rx_cyc_q <= rx_cyc_d;
         bclk_q <= bclk_d;
         bclk_prev_q <= bclk_s;
         txfs_prev_q <= txfs_prev_d;
         rxfs_prev_q <= rxfs_prev_d;
         txfs_o_q <= txfs_o_d;
         rxfs_o_q <= rxfs_o_d;
         rxo_q <= rxo_d;
         rxoe_q <= rxoe_d;
         strobe_q <= strobe_d;
         tx_sr_q <= tx_sr_d;
         rx_word_q <= rx_word_d;
         tx_word_q <= tx_word_d;
      end
   end

   assign o_bclk = bclk_q;
   assign o_tx_frame_sync = txfs_o_q;
   assign o_rx_frame_sync = rxfs_o_q;
   assign o_serial_rx_out = rxo_q;
   assign o_serial_rx_out_oe = rxoe_q;
   assign {o_tx_b1, o_tx_b2, o_tx_d} = tx_word_q;
   assign o_tx_strobe = strobe_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   master_sync_a: assert property (master && o_tx_frame_sync |-> tx_cyc_q == 10'h000)
      else $error("tx frame sync out of place");
   gci_slave_a: assert property (gci && !master |-> !o_bclk_oe && !o_tx_frame_sync_oe)
      else $error("GCI slave drives clock pins");
   lt_role_a: assert property (gci && !master |-> o_nt_mode == !i_lt_mode)
      else $error("GCI slave role not from configuration");
   gci_master_a: assert property (gci && master |-> o_nt_mode && o_bclk_oe && o_rx_frame_sync_oe)
      else $error("GCI master not forced");
   gci_hold_a: assert property (gci && rise && rx_cyc_d[0] |=> $stable(o_serial_rx_out))
      else $error("GCI bit changed mid bit");
   rx_float_a: assert property (o_serial_rx_out_oe |-> dfp_bit_idx(rx_cyc_q, gci) < last_bit)
      else $error("receive output driven outside slot");
   clk_div_a: assert property (master && div_wrap |=> div_q == 10'h000 && o_bclk != $past(o_bclk))
      else $error("bit clock divider slip");
   sync_restart_a: assert property (!master && tx_start |=> tx_cyc_q == 10'h000)
      else $error("counter not restarted on sync");
   d_drop_a: assert property (o_tx_strobe && !d_route |-> o_tx_d == 2'h0)
      else $error("D bits taken without routing");

endmodule

/* sim/dfp_far_end.sv */
// Far-end backplane model: bit clock, frame syncs and serial data for slave modes.
// Assumes the bench resolves shared pins and calls run_frame from its main sequence.
`timescale 1ns/1ps
module dfp_far_end (
   // Core clock, used only to align edges
   input wire logic i_core_clk,
   // Port data pin
   input wire logic i_rx_out,
   input wire logic i_rx_oe,
   // Driven pins
   output logic o_bclk,
   output logic o_tx_fs,
   output logic o_rx_fs,
   output logic o_tx_in
);
   initial
   begin
      o_bclk = 1'b0;
      o_tx_fs = 1'b0;
      o_rx_fs = 1'b0;
      o_tx_in = 1'b0;
   end
   // ************************************************************
   // One frame at 48 ns per bit clock; the clock stands still between frames
   // ************************************************************
   task automatic run_frame(input int gci, input int nbits, input logic [17:0] tx,
      output logic [17:0] rx, output int bad);
      int ncyc;
      int idx;
      ncyc = gci ? 2 * nbits : nbits;
      rx = '0;
      bad = 0;
      @(negedge i_core_clk);
      for (int cyc = -2; cyc < ncyc + 2; cyc++)
      begin
         idx = (cyc < 0) ? 0 : (gci ? cyc / 2 : cyc);
         o_bclk = 1'b1;
         o_tx_fs = (cyc == 0);
         o_rx_fs = (cyc == 0);
         // Outside the slot the line shows the inverse, so a stale bit never passes
         o_tx_in = (cyc >= 0 && cyc < ncyc) ? tx[17 - idx] : ~o_tx_in;
         // Bench bit clock is far above the slave range to keep the run short
         #24;
         o_bclk = 1'b0;
         if (cyc >= 0 && cyc < ncyc && (gci == 0 || cyc % 2 == 1))
         begin
            if (i_rx_oe !== 1'b1) bad++;
            rx[17 - idx] = i_rx_out;
         end
         if (cyc == ncyc + 1 && i_rx_oe !== 1'b0) bad++;
         #24;
      end
   endtask
endmodule

/* sim/dfp_port_tb_top.sv */
// Testbench for the serial frame port: slave frames, master clocks and frame syncs.
// Assumes dfp_far_end drives the pins whenever the port leaves them as inputs.
`timescale 1ns/1ps
module dfp_port_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fmt = 1'b1, cdir = 1'b0, gsel = 1'b0, tdm_m = 1'b0, droute = 1'b0, lt = 1'b0;
   logic [2:0] rate = 3'h0;
   logic [7:0] rb1 = 8'h00, rb2 = 8'h00, tb1, tb2;
   logic [1:0] rd = 2'h0, td;
   logic f_bclk, f_tfs, f_rfs, f_txd, bclk_w, tfs_w, rfs_w;
   logic o_bclk, bclk_oe, o_tfs, tfs_oe, o_rfs, rfs_oe, rx_out, rx_oe, strobe, nt, gci, mst;
   int error_cnt = 0, total_checks = 0, strobe_cnt = 0, n, k;
   int hz[5] = '{256000, 512000, 1536000, 2048000, 2560000};
   integer seed = 32'hf2fc2696;

   always #2 clk = ~clk;
   assign bclk_w = bclk_oe ? o_bclk : f_bclk;
   assign tfs_w = tfs_oe ? o_tfs : f_tfs;
   assign rfs_w = rfs_oe ? o_rfs : f_rfs;
   always @(negedge clk) if (strobe === 1'b1) strobe_cnt++;

   dfp_port u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_format_select_pin(fmt),
      .i_clock_direction_select(cdir), .i_gci_clk_select(gsel), .i_tdm_master(tdm_m),
      .i_bclk_rate_sel(rate), .i_d_route_en(droute), .i_lt_mode(lt), .i_bclk(bclk_w),
      .o_bclk(o_bclk), .o_bclk_oe(bclk_oe), .i_tx_frame_sync(tfs_w), .o_tx_frame_sync(o_tfs),
      .o_tx_frame_sync_oe(tfs_oe), .i_rx_frame_sync(rfs_w), .o_rx_frame_sync(o_rfs),
      .o_rx_frame_sync_oe(rfs_oe), .i_serial_tx_in(f_txd), .o_serial_rx_out(rx_out),
      .o_serial_rx_out_oe(rx_oe), .o_tx_b1(tb1), .o_tx_b2(tb2), .o_tx_d(td),
      .o_tx_strobe(strobe), .i_rx_b1(rb1), .i_rx_b2(rb2), .i_rx_d(rd), .o_nt_mode(nt),
      .o_gci_mode(gci), .o_master(mst));
   dfp_far_end u_far (.i_core_clk(clk), .i_rx_out(rx_out), .i_rx_oe(rx_oe),
      .o_bclk(f_bclk), .o_tx_fs(f_tfs), .o_rx_fs(f_rfs), .o_tx_in(f_txd));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic set_mode(input logic f, input logic d, input logic m, input int r,
      input logic g);
      @(negedge clk);
      fmt = f;
      cdir = d;
      tdm_m = m;
      rate = 3'(r);
      gsel = g;
      repeat (8) @(negedge clk);
   endtask
   // Core cycles until the next rise of the driven bit clock, bounded
   task automatic next_rise(output int c);
      logic prev;
      c = 0;
      prev = o_bclk;
      while (!(o_bclk === 1'b1 && prev === 1'b0) && c < 2000)
      begin
         prev = o_bclk;
         @(negedge clk);
         c++;
      end
   endtask
   task automatic slave_frame(input int g, input int dr);
      logic [17:0] tx;
      logic [17:0] rx;
      logic [17:0] ex;
      int bad;
      int s0;
      tx = 18'($random(seed));
      @(negedge clk);
      droute = dr[0];
      rb1 = 8'($random(seed));
      rb2 = 8'($random(seed));
      rd = 2'($random(seed));
      ex = {rb1, rb2, dr ? rd : 2'h0};
      s0 = strobe_cnt;
      u_far.run_frame(g, dr ? 18 : 16, tx, rx, bad);
      repeat (4) @(negedge clk);
      chk("rx_bits", 32'(rx), 32'(ex));
      chk("rx_oe_slot", bad, 0);
      chk("tx_words", {tb1, tb2, td}, {tx[17:2], dr ? tx[1:0] : 2'h0});
      chk("strobes", strobe_cnt - s0, 1);
   endtask

   initial
   begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      // Slave frames: TDM then GCI, each without and with D routing
      for (int i = 0; i < 4; i++)
      begin
         set_mode(i < 2, 1'b0, 1'b0, 0, 1'b0);
         lt = i[0];
         repeat (2) @(negedge clk);
         if (i >= 2)
         begin
            chk("nt_mode", nt, !lt);
            chk("slave_oe", {bclk_oe, tfs_oe, gci}, 3'h1);
         end
         slave_frame(i >= 2, i % 2);
      end
      // TDM master: every rate, then one whole frame at the last one
      for (int r = 0; r < 5; r++)
      begin
         set_mode(1'b1, 1'b0, 1'b1, r, 1'b0);
         next_rise(n);
         next_rise(n);
         chk("bclk_period", n, 2 * (250000000 / (2 * hz[r])));
         chk("master_oe", {bclk_oe, tfs_oe, rfs_oe, mst}, 4'hf);
      end
      // First pass finds a sync, second counts one whole frame
      for (int p = 0; p < 2; p++)
      begin
         k = 0;
         do
         begin
            next_rise(n);
            repeat (2) @(negedge clk);
            k++;
         end
         while (o_tfs !== 1'b1 && k < 400);
      end
      chk("frame_len", k, 2560000 / 8000);
      chk("rx_sync", o_rfs, 1);
      // GCI master at both clock selects; role forced regardless of config
      lt = 1'b1;
      for (int g = 0; g < 2; g++)
      begin
         set_mode(1'b0, 1'b1, 1'b0, 0, g[0]);
         next_rise(n);
         next_rise(n);
         chk("gci_period", n, 2 * (250000000 / (2 * (g ? 1536000 : 512000))));
         chk("gci_master", {bclk_oe, tfs_oe, rfs_oe, nt, gci}, 5'h1f);
      end
      tally_and_finish();
   end
   // Run needs about 66k core cycles; the limit leaves margin
   initial
   begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
